// ### dv/nvsq_host_tb_top.sv
// self-checking bench for the nv-sram host sequencer against the memory model
`timescale 1ns/10ps
module nvsq_host_tb_top;
  import nvsq_pkg::*;
  typedef struct {
    nvsq_op_type op;
    logic [16:0] a;
    logic [7:0]  d;
    logic [7:0]  rd;
    logic        pend;
    logic        as_en;
  } nvsq_row_type;
  logic              mclk, sys_rst, req_valid, req_ready, rsp_valid, mode_store_pend;
  logic              busy_n, pwr_cycle, autosave_en, nv_autosave, cs_q, clk_en;
  logic [DATA_W-1:0] rsp_rdata, din;
  nvsq_req_type      req;
  nvsq_pins_type     pins;
  logic [16:0]       addr_q [$];
  int                err_count, total_checks, i, k;
  logic [15:0]       exp_a;
  nvsq_row_type rows [11] = '{
    '{NVSQ_OP_WRITE, 17'h1_0004, 8'hA5, 8'h00, 1'b0, 1'b1},
    '{NVSQ_OP_WRITE, 17'h0_0004, 8'h3C, 8'h00, 1'b0, 1'b1},
    '{NVSQ_OP_READ,  17'h1_0004, 8'h00, 8'hA5, 1'b0, 1'b1},
    '{NVSQ_OP_READ,  17'h0_0004, 8'h00, 8'h3C, 1'b0, 1'b1},
    '{NVSQ_OP_ASDIS, 17'h0_0000, 8'h00, 8'h00, 1'b1, 1'b0},
    '{NVSQ_OP_STORE, 17'h0_0000, 8'h00, 8'h00, 1'b0, 1'b0},
    '{NVSQ_OP_WRITE, 17'h0_0004, 8'h77, 8'h00, 1'b0, 1'b0},
    '{NVSQ_OP_READ,  17'h0_0004, 8'h00, 8'h77, 1'b0, 1'b0},
    '{NVSQ_OP_RECALL, 17'h0_0000, 8'h00, 8'h00, 1'b0, 1'b0},
    '{NVSQ_OP_READ,  17'h0_0004, 8'h00, 8'h3C, 1'b0, 1'b0},
    '{NVSQ_OP_ASEN,  17'h0_0000, 8'h00, 8'h00, 1'b1, 1'b1}};
  nvsq_host u_dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .mode_store_pend(mode_store_pend), .pins(pins), .data_pins_in(din),
    .hardware_save_busy_line_n(busy_n));
  nvsq_mem_model u_mem (.mclk(mclk), .pwr_cycle(pwr_cycle), .pins(pins), .data_pins_in(din),
    .hardware_save_busy_line_n(busy_n), .autosave_en(autosave_en), .nv_autosave(nv_autosave));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // every chip-select fall is logged with the write strobe level beside the address
  always @(posedge mclk) begin
    cs_q <= pins.chip_sel_n;
    if (cs_q === 1'b1 && pins.chip_sel_n === 1'b0) begin
      addr_q.push_back({pins.wr_strobe_n, pins.addr[15:0]});
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic do_op(input nvsq_op_type op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr_q.delete();
    while (req_ready !== 1'b1 && n < 100) begin @(negedge mclk); n++; end
    req_valid = 1'b1;
    req = '{op, a, d};
    // hold the request until the sequencer shows it is taken
    do begin @(negedge mclk); n++; end while (req_ready === 1'b1 && n < 200);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 1000) begin @(negedge mclk); n++; end
    if (n >= 1000) err_count++;
  endtask : do_op
  task automatic pulse_power;
    pwr_cycle = 1'b1;
    @(negedge mclk);
    pwr_cycle = 1'b0;
    @(negedge mclk);
  endtask : pulse_power
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req = '0;
    pwr_cycle = 1'b0;
    repeat (3) @(negedge mclk);
    chk(req_ready, 1'b0);
    chk(pins.chip_sel_n, 1'b1);
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    chk(autosave_en, 1'b1);
    for (i = 0; i < 11; i++) begin
      do_op(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].op == NVSQ_OP_READ) chk(rsp_rdata, rows[i].rd);
      chk(mode_store_pend, rows[i].pend);
      chk(autosave_en, rows[i].as_en);
      if (rows[i].op >= NVSQ_OP_STORE) begin
        chk(32'(addr_q.size()), 32'h0000_0006);
        for (k = 0; k < 6 && k < addr_q.size(); k++) begin
          case (k)
            0: exp_a = PRE_ADDR0;
            1: exp_a = PRE_ADDR1;
            2: exp_a = PRE_ADDR2;
            3: exp_a = PRE_ADDR3;
            4: exp_a = PRE_ADDR4;
            default: exp_a = (rows[i].op == NVSQ_OP_STORE) ? CMD_STORE :
                             (rows[i].op == NVSQ_OP_RECALL) ? CMD_RECALL :
                             (rows[i].op == NVSQ_OP_ASDIS) ? CMD_DISABLE : CMD_ENABLE;
          endcase
          chk(addr_q[k], {1'b1, exp_a});
        end
      end
      if (rows[i].op == NVSQ_OP_STORE) chk(nv_autosave, 1'b0);
    end
    // frozen clock enable: a pending write must not be taken, memory stays deselected
    clk_en = 1'b0;
    req_valid = 1'b1;
    req = '{NVSQ_OP_WRITE, 17'h0_0004, 8'hEE};
    repeat (4) @(negedge mclk);
    chk(req_ready, 1'b1);
    chk(pins.chip_sel_n, 1'b1);
    req_valid = 1'b0;
    clk_en = 1'b1;
    do_op(NVSQ_OP_READ, 17'h0_0004, 8'h00);
    chk(rsp_rdata, 8'h3C);
    // reset in the middle of a store prefix: the sixth read never reaches the memory
    req_valid = 1'b1;
    req = '{NVSQ_OP_STORE, 17'h0_0000, 8'h00};
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (20) @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk(req_ready, 1'b0);
    chk(pins.chip_sel_n, 1'b1);
    chk(mode_store_pend, 1'b0);
    sys_rst = 1'b0;
    chk(nv_autosave, 1'b0);
    // enable was issued but never stored, so a power-down brings back the stored disable
    pulse_power();
    chk(autosave_en, 1'b0);
    do_op(NVSQ_OP_ASEN, 17'h0_0000, 8'h00);
    do_op(NVSQ_OP_STORE, 17'h0_0000, 8'h00);
    chk(mode_store_pend, 1'b0);
    do_op(NVSQ_OP_READ, 17'h1_0004, 8'h00);
    chk(rsp_rdata, 8'hA5);
    pulse_power();
    chk(autosave_en, 1'b1);
    tally_and_finish();
  end
endmodule : nvsq_host_tb_top

// ### dv/nvsq_mem_model.sv
// behavioural nv-sram seen from the host: byte array, six-read command decoder, busy line
`timescale 1ns/10ps
module nvsq_mem_model
  import nvsq_pkg::*;
#(
  parameter int BUSY_CYC = 20
) (
  // clock and power events
  input  wire logic           mclk,
  input  wire logic           pwr_cycle,
  // memory pins
  input  wire nvsq_pins_type  pins,
  output logic [DATA_W-1:0]   data_pins_in,
  output logic                hardware_save_busy_line_n,
  // state shown to the bench
  output logic                autosave_en,
  output logic                nv_autosave
);
  localparam logic [15:0] SEQ [0:4] = '{PRE_ADDR0, PRE_ADDR1, PRE_ADDR2, PRE_ADDR3, PRE_ADDR4};
  logic [7:0]        mem    [0:(1<<ADDR_W)-1];
  logic [7:0]        nv_mem [0:(1<<ADDR_W)-1];
  logic [2:0]        step;
  logic              cs_q;
  logic [DATA_W-1:0] last_q;
  int                busy_cnt;
  wire               busy     = (busy_cnt != 0);
  wire               cs_fall  = cs_q && !pins.chip_sel_n;
  wire [15:0]        a16      = pins.addr[15:0];
  // no pull on the data lines: when released they show the inverse of the last value
  wire rd_drive = !pins.chip_sel_n && pins.wr_strobe_n && !pins.out_en_n && !busy;
  assign data_pins_in = rd_drive ? mem[pins.addr] : ~last_q;
  assign hardware_save_busy_line_n = !busy; // pulled up when released
  initial begin
    autosave_en = 1'b1;
    nv_autosave = 1'b1;
    step = 3'h0;
    cs_q = 1'b1;
    busy_cnt = 0;
    last_q = 8'h00;
  end
  // ==========================================================================
  // array, command decoder, power events
  // ==========================================================================
  always @(posedge mclk) begin
    cs_q <= pins.chip_sel_n;
    last_q <= data_pins_in;
    if (busy) busy_cnt <= busy_cnt - 1;
    if (pwr_cycle) autosave_en <= nv_autosave;
    if (!pins.chip_sel_n && !pins.wr_strobe_n && !busy) mem[pins.addr] <= pins.data_out;
    if (cs_fall && !busy) begin
      if (!pins.wr_strobe_n) step <= 3'h0;
      else if (step < 5 && a16 == SEQ[step]) step <= step + 3'h1;
      else begin
        step <= (a16 == PRE_ADDR0) ? 3'h1 : 3'h0;
        if (step == 5) begin
          case (a16)
            CMD_DISABLE: autosave_en <= 1'b0;
            CMD_ENABLE:  autosave_en <= 1'b1;
            CMD_STORE: begin
              nv_mem <= mem;
              nv_autosave <= autosave_en;
              busy_cnt <= BUSY_CYC;
            end
            CMD_RECALL: begin
              mem <= nv_mem;
              busy_cnt <= BUSY_CYC;
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule : nvsq_mem_model

// ### logic/nvsq_host.sv
// host sequencer driving an nv-sram port: plain accesses and six-read commands
// ============================================================================
// ============================================================================
`timescale 1ns/10ps
module nvsq_host
  import nvsq_pkg::*;
(
  // clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // user request
  input  wire logic              req_valid,
  input  wire nvsq_req_type      req,
  output logic                   req_ready,
  // user answer
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   mode_store_pend,
  // memory pins
  output nvsq_pins_type          pins,
  input  wire logic [DATA_W-1:0] data_pins_in,
  input  wire logic              hardware_save_busy_line_n
);

  // ==========================================================================
  // state machine
  // ==========================================================================
  typedef enum logic [2:0] {
    NVSQ_IDLE  = 3'b000,
    NVSQ_SETUP = 3'b001,
    NVSQ_STROB = 3'b011,
    NVSQ_HOLD  = 3'b010,
    NVSQ_BUSY  = 3'b110
  } nvsq_state_type;

  nvsq_state_type      state_ff, nxt_state;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt;
  logic [2:0]          step_ff, nxt_step;
  nvsq_req_type        cur_ff, nxt_cur;
  nvsq_pins_type       pins_ff, nxt_pins;
  logic                ready_ff, rsp_ff, pend_ff;
  logic [DATA_W-1:0]   rdata_ff;
  logic [DATA_W-1:0]   din_s;
  logic                busy_n_s;

  nvsq_sync #(.W(DATA_W + 1)) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({hardware_save_busy_line_n, data_pins_in}),
    .sync_out ({busy_n_s, din_s})
  );

  // ==========================================================================
  // decode
  // ==========================================================================
  wire is_cmd     = (cur_ff.op != NVSQ_OP_READ) && (cur_ff.op != NVSQ_OP_WRITE);
  wire is_write   = (cur_ff.op == NVSQ_OP_WRITE);
  wire phase_done = (cnt_ff == PHASE_LAST);
  wire last_step  = !is_cmd || (step_ff == 3'(SEQ_LEN - 1));
  wire mode_op    = (cur_ff.op == NVSQ_OP_ASDIS) || (cur_ff.op == NVSQ_OP_ASEN);
  // an nv op cycle is the sixth read of a store or recall
  wire nv_float   = is_cmd && last_step && !mode_op;
  wire [15:0] final_addr =
      (cur_ff.op == NVSQ_OP_STORE)  ? CMD_STORE :
      (cur_ff.op == NVSQ_OP_RECALL) ? CMD_RECALL :
      (cur_ff.op == NVSQ_OP_ASDIS)  ? CMD_DISABLE : CMD_ENABLE;
  // upper address line is don't-care for the memory; keep it zero
  wire [15:0] step_addr =
      (step_ff == 3'd0) ? PRE_ADDR0 :
      (step_ff == 3'd1) ? PRE_ADDR1 :
      (step_ff == 3'd2) ? PRE_ADDR2 :
      (step_ff == 3'd3) ? PRE_ADDR3 :
      (step_ff == 3'd4) ? PRE_ADDR4 : final_addr;
  wire [ADDR_W-1:0] drive_addr = is_cmd ? {1'b0, step_addr} : cur_ff.addr;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_step  = step_ff;
    nxt_cur   = cur_ff;
    nxt_pins  = pins_ff;
    case (state_ff)
      NVSQ_IDLE: begin
        // strobes high, bus released: memory is deselected between accesses
        nxt_pins.chip_sel_n  = 1'b1;
        nxt_pins.wr_strobe_n = 1'b1;
        nxt_pins.out_en_n    = 1'b1;
        nxt_pins.data_oe     = 1'b0;
        if (req_valid) begin
          nxt_cur   = req;
          nxt_step  = 3'd0;
          nxt_cnt   = '0;
          nxt_state = NVSQ_SETUP;
        end
      end
      NVSQ_SETUP: begin
        nxt_pins.addr     = drive_addr;
        nxt_pins.data_out = cur_ff.wdata;
        nxt_pins.data_oe  = is_write;
        nxt_state         = NVSQ_STROB;
        nxt_cnt           = '0;
      end
      NVSQ_STROB: begin
        // command cycles are reads only, never a write strobe
        nxt_pins.chip_sel_n  = 1'b0;
        nxt_pins.wr_strobe_n = !is_write;
        // output enable low for every read, command prefix reads included; float on the nv op cycle
        nxt_pins.out_en_n    = is_write || nv_float;
        nxt_cnt              = cnt_ff + 1'b1;
        if (phase_done) begin
          nxt_cnt   = '0;
          nxt_state = NVSQ_HOLD;
        end
      end
      NVSQ_HOLD: begin
        nxt_pins.chip_sel_n  = 1'b1;
        nxt_pins.wr_strobe_n = 1'b1;
        nxt_pins.out_en_n    = 1'b1;
        nxt_pins.data_oe     = 1'b0;
        // no other access is interleaved: the sequence runs back to back
        if (!last_step) begin
          nxt_step  = step_ff + 3'd1;
          nxt_state = NVSQ_SETUP;
        end else if (nv_float) begin
          nxt_state = NVSQ_BUSY;
        end else begin
          nxt_state = NVSQ_IDLE;
        end
      end
      NVSQ_BUSY: begin
        // hold off until the memory releases its busy line
        nxt_cnt = (cnt_ff == PHASE_LAST) ? cnt_ff : cnt_ff + 1'b1;
        if (phase_done && busy_n_s) begin
          nxt_state = NVSQ_IDLE;
        end
      end
      default: begin
        nxt_state = NVSQ_IDLE;
      end
    endcase
  end

  wire sample_rd = (state_ff == NVSQ_STROB) && phase_done && !is_cmd && !is_write;
  wire finish    = (nxt_state == NVSQ_IDLE) && (state_ff != NVSQ_IDLE);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= NVSQ_IDLE;
      cnt_ff   <= '0;
      step_ff  <= 3'd0;
      cur_ff   <= '0;
      pins_ff  <= '{chip_sel_n: 1'b1, wr_strobe_n: 1'b1, out_en_n: 1'b1, default: '0};
      ready_ff <= 1'b0;
      rsp_ff   <= 1'b0;
      rdata_ff <= '0;
      pend_ff  <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      step_ff  <= nxt_step;
      cur_ff   <= nxt_cur;
      pins_ff  <= nxt_pins;
      ready_ff <= (nxt_state == NVSQ_IDLE);
      rsp_ff   <= finish;
      if (sample_rd) begin
        rdata_ff <= din_s;
      end
      // mode change is volatile until a store follows it
      if (finish && mode_op) begin
        pend_ff <= 1'b1;
      end else if (finish && cur_ff.op == NVSQ_OP_STORE) begin
        pend_ff <= 1'b0;
      end
    end
  end

  assign req_ready       = ready_ff;
  assign rsp_valid       = rsp_ff;
  assign rsp_rdata       = rdata_ff;
  assign mode_store_pend = pend_ff;
  assign pins            = pins_ff;

  // ==========================================================================
  // assertions
  // ==========================================================================
  // a frozen cycle stretches every step, so the checks pause while clk_en is low
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || !clk_en);

  a_we_high_cmd: assert property (
      is_cmd && state_ff != NVSQ_IDLE |-> pins_ff.wr_strobe_n)
    else $error("write strobe low during command sequence");
  a_prefix_first: assert property (
      state_ff == NVSQ_SETUP && is_cmd && step_ff == 3'd0
      |=> pins_ff.addr[15:0] == PRE_ADDR0)
    else $error("command does not open with first prefix address");
  a_prefix_mid: assert property (
      state_ff == NVSQ_SETUP && is_cmd && step_ff == 3'd2
      |=> pins_ff.addr[15:0] == PRE_ADDR2)
    else $error("third prefix address wrong");
  a_store_addr: assert property (
      state_ff == NVSQ_SETUP && cur_ff.op == NVSQ_OP_STORE && step_ff == 3'd5
      |=> pins_ff.addr[15:0] == CMD_STORE)
    else $error("store final address wrong");
  a_store_float: assert property (
      state_ff == NVSQ_STROB && cur_ff.op == NVSQ_OP_STORE && step_ff == 3'd5
      |=> pins_ff.out_en_n)
    else $error("output enable low on store cycle");
  a_recall_float: assert property (
      state_ff == NVSQ_STROB && cur_ff.op == NVSQ_OP_RECALL && step_ff == 3'd5
      |=> pins_ff.out_en_n)
    else $error("output enable low on recall cycle");
  a_disable_addr: assert property (
      state_ff == NVSQ_SETUP && cur_ff.op == NVSQ_OP_ASDIS && step_ff == 3'd5
      |=> pins_ff.addr[15:0] == CMD_DISABLE)
    else $error("disable final address wrong");
  a_enable_addr: assert property (
      state_ff == NVSQ_SETUP && cur_ff.op == NVSQ_OP_ASEN && step_ff == 3'd5
      |=> pins_ff.addr[15:0] == CMD_ENABLE)
    else $error("enable final address wrong");
  a_no_interleave: assert property (
      state_ff == NVSQ_HOLD && is_cmd && !last_step |=> state_ff == NVSQ_SETUP)
    else $error("command sequence broken");
  a_top_bit_zero: assert property (
      is_cmd && state_ff == NVSQ_STROB |-> !pins_ff.addr[16])
    else $error("upper address bit set in command");
  a_idle_desel: assert property (
      state_ff == NVSQ_IDLE && $past(state_ff) == NVSQ_IDLE
      |-> pins_ff.chip_sel_n && !pins_ff.data_oe)
    else $error("memory selected while idle");
  a_busy_float: assert property (
      state_ff == NVSQ_BUSY |-> pins_ff.chip_sel_n && pins_ff.out_en_n && !pins_ff.data_oe)
    else $error("memory pins active while store or recall runs");
  a_write_oe_off: assert property (
      !pins_ff.wr_strobe_n |-> pins_ff.out_en_n)
    else $error("output enable low during write strobe");

  c_store: cover property (finish && cur_ff.op == NVSQ_OP_STORE);
  c_read: cover property (rsp_ff && $past(cur_ff.op) == NVSQ_OP_READ);
  c_write: cover property (finish && is_write);
  c_mode: cover property (pend_ff);

endmodule : nvsq_host

// ### logic/nvsq_pkg.sv
// package: pin groups, command addresses and cycle timing for the nv-sram host sequencer
package nvsq_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // ==========================================================================
  // command address prefix and final addresses (low sixteen address bits)
  // ==========================================================================
  localparam logic [15:0] PRE_ADDR0 = 16'h4E38;
  localparam logic [15:0] PRE_ADDR1 = 16'hB1C7;
  localparam logic [15:0] PRE_ADDR2 = 16'h83E0;
  localparam logic [15:0] PRE_ADDR3 = 16'h7C1F;
  localparam logic [15:0] PRE_ADDR4 = 16'h703F;
  localparam logic [15:0] CMD_DISABLE = 16'h8B45;
  localparam logic [15:0] CMD_ENABLE  = 16'h4B46;
  localparam logic [15:0] CMD_STORE   = 16'h8FC0;
  localparam logic [15:0] CMD_RECALL  = 16'h4C63;
  localparam int          SEQ_LEN     = 6;

  // ==========================================================================
  // timing: one strobe phase, in ns and in mclk cycles at 100 mhz
  // ==========================================================================
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          PHASE_NS      = 50;
  localparam int          PHASE_CYC     = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 4;
  localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_CYC - 1);

  // user command codes
  typedef enum logic [2:0] {
    NVSQ_OP_READ    = 3'h0,
    NVSQ_OP_WRITE   = 3'h1,
    NVSQ_OP_STORE   = 3'h2,
    NVSQ_OP_RECALL  = 3'h3,
    NVSQ_OP_ASDIS   = 3'h4,
    NVSQ_OP_ASEN    = 3'h5
  } nvsq_op_type;

  // pins driven towards the memory
  typedef struct packed {
    logic              chip_sel_n;
    logic              wr_strobe_n;
    logic              out_en_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
  } nvsq_pins_type;

  // user request
  typedef struct packed {
    nvsq_op_type       op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } nvsq_req_type;

endpackage : nvsq_pkg

// ### logic/nvsq_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module nvsq_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : nvsq_sync
